/* hw/cba_map.svh */
/*
 * constants for the bus arbitration and bus exception block.
 * assumes inclusion by bare name from the package and the design module.
 */
`ifndef CBA_MAP_SVH
`define CBA_MAP_SVH
`define CBA_ADDR_W 32
`define CBA_DATA_W 32
`define CBA_SIZE_W 3
`define CBA_STAT_W 4
`define CBA_XMD_W 2
`define CBA_SYNC_W 2
`define CBA_RST_SAMPLES 2'h2
`define CBA_RST_ACK_HOLD 4'h4
`define CBA_ZERO1 1'h0
`define CBA_ONE1 1'h1
`endif

/* hw/cba_pkg.sv */
/*
 * types for the bus arbitration and bus exception block.
 * assumes cba_map.svh is on the include path.
 */
`include "cba_map.svh"
package cba_pkg;
  typedef enum logic [2:0] {
    CBA_IDLE,
    CBA_REQ,
    CBA_OWN,
    CBA_GRANT,
    CBA_RST
  } cba_state_t;

  typedef struct packed {
    cba_state_t state;
    logic [`CBA_SYNC_W-1:0] bus_request_line_sync;
    logic [`CBA_SYNC_W-1:0] grant_sync;
    logic [`CBA_SYNC_W-1:0] rstrq_sync;
    logic [`CBA_SYNC_W-1:0] fault_sync;
    logic [`CBA_SYNC_W-1:0] release_sync;
    logic [`CBA_SYNC_W-1:0] preempt_sync;
    logic [`CBA_SYNC_W-1:0] tack_sync;
    logic [1:0] rst_cnt;
    logic [3:0] ack_cnt;
    logic tack_seen;
    logic fault;
    logic reset_ack;
    logic bus_request_line_out;
    logic grant_out;
    logic own_bus;
    logic start_routine;
  } cba_regs_t;
endpackage

/* hw/cba_core.sv */
/*
 * bus ownership, arbitration and bus exception logic of the processor.
 * assumes the core supplies bus values on ref_clk; pins come from outside
 * and, except the static strap, are synchronised here; the pad ring resolves enables to wires.
 */
// Functional notes
// R01: strap low: arbiter, use bus without request
// R02: strap high: request bus before use
// R03: non-arbiter floats bus outputs until granted
// R04: grant pin output as arbiter, else input
// R05: arbiter floats bus then grants requester
// R06: non-arbiter owns bus only after grant
// R07: request pin direction follows strap, input synchronised
// R08: external master raises request to arbiter
// R09: non-arbiter raises request output for ownership
// R10: abort on cache-hit discontinuity or alignment fault
// R11: memory ignores accesses marked with abort
// R12: release input floats data, ready, size, direction
// R13: memory manager raises release to take data bus
// R14: fault double sampled before ack, single after
// R15: fault ignored while release asserted
// R16: reset acknowledge on external or internal reset
// R17: reset routine starts after acknowledge drops
// R18: reset request accepted after two samples
// R19: preemption freezes response to arbitration signals
// R20: grant held until request drops, then resume
`timescale 1ns/1ns
`include "cba_map.svh"
module cba_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // strap and exception pins
  input wire logic arbiter_select_strap,
  input wire logic data_bus_release_in,
  input wire logic transfer_ack_in,
  input wire logic reset_request_in,
  input wire logic preemption_request_in,
  input wire logic fault_in,
  // requests from the core
  input wire logic core_bus_need,
  input wire logic core_cache_hit_discont,
  input wire logic core_align_fault,
  input wire logic core_reset_exception,
  input wire logic core_bus_active,
  // core bus values
  input wire logic [`CBA_ADDR_W-1:0] core_addr,
  input wire logic [`CBA_DATA_W-1:0] core_wdata,
  input wire logic core_data_we,
  input wire logic core_as,
  input wire logic core_ds,
  input wire logic core_cycle_init,
  input wire logic core_data_ready_out,
  input wire logic [`CBA_SIZE_W-1:0] core_size,
  input wire logic core_read_write,
  input wire logic [`CBA_STAT_W-1:0] core_status,
  input wire logic core_vad,
  input wire logic [`CBA_XMD_W-1:0] core_xmd,
  // status to the core
  output logic bus_owned,
  output logic fault_seen,
  output logic reset_routine_start,
  // grant pin, two-way
  input wire logic grant_acknowledge_i,
  output logic grant_acknowledge_o,
  output logic grant_acknowledge_oe,
  // request pin, two-way
  input wire logic bus_request_line_i,
  output logic bus_request_line_o,
  output logic bus_request_line_oe,
  // reset acknowledge
  output logic reset_ack_out,
  // address side outputs and enable
  output logic access_abort_out,
  output logic [`CBA_ADDR_W-1:0] address_out,
  output logic address_strobe_out,
  output logic data_strobe_out,
  output logic cycle_initiate_out,
  output logic [`CBA_STAT_W-1:0] access_status_out,
  output logic virtual_address_flag,
  output logic [`CBA_XMD_W-1:0] execution_level_out,
  output logic addr_side_oe,
  // data side outputs and enable
  output logic [`CBA_DATA_W-1:0] data_out,
  output logic data_ready_out,
  output logic [`CBA_SIZE_W-1:0] transfer_size_out,
  output logic read_write_out,
  output logic data_side_oe,
  output logic data_bus_oe
);
  cba_pkg::cba_regs_t r_reg, r_next;

  // two-stage shift used by every pin synchroniser
  function automatic logic [`CBA_SYNC_W-1:0] sync2(
    input logic [`CBA_SYNC_W-1:0] s, input logic d);
    sync2 = {s[0], d};
  endfunction

  logic is_arbiter;
  logic ext_req;
  logic ext_grant;
  logic rel;
  logic preempt;
  logic fault_now;

  // strap is static after reset, read directly
  assign is_arbiter = ~arbiter_select_strap; // R01 R02
  assign ext_req = r_reg.bus_request_line_sync[1]; // R07 R08
  assign ext_grant = r_reg.grant_sync[1];
  assign rel = r_reg.release_sync[1];
  assign preempt = r_reg.preempt_sync[1];

  always_comb begin
    r_next = r_reg;
    r_next.bus_request_line_sync = sync2(r_reg.bus_request_line_sync, bus_request_line_i); // R07
    r_next.grant_sync = sync2(r_reg.grant_sync, grant_acknowledge_i);
    r_next.rstrq_sync = sync2(r_reg.rstrq_sync, reset_request_in);
    r_next.fault_sync = sync2(r_reg.fault_sync, fault_in);
    r_next.release_sync = sync2(r_reg.release_sync, data_bus_release_in);
    r_next.preempt_sync = sync2(r_reg.preempt_sync, preemption_request_in);
    r_next.tack_sync = sync2(r_reg.tack_sync, transfer_ack_in);
    r_next.start_routine = `CBA_ZERO1;
    if (r_reg.tack_sync[1]) begin
      r_next.tack_seen = `CBA_ONE1;
    end else if (!core_bus_active) begin
      r_next.tack_seen = `CBA_ZERO1;
    end
    // after ack the fault is taken one stage earlier
    fault_now = r_reg.tack_seen ? r_reg.fault_sync[0]
                                : r_reg.fault_sync[1]; // R14
    r_next.fault = fault_now & ~rel; // R15
    // reset request counted over consecutive samples
    if (r_reg.rstrq_sync[1]) begin
      if (r_reg.rst_cnt != `CBA_RST_SAMPLES) begin
        r_next.rst_cnt = r_reg.rst_cnt + 2'h1;
      end
    end else begin
      r_next.rst_cnt = 2'h0;
    end
    case (r_reg.state)
      cba_pkg::CBA_IDLE: begin
        r_next.bus_request_line_out = `CBA_ZERO1;
        r_next.own_bus = is_arbiter; // R01
        if (is_arbiter && ext_req && !preempt) begin // R19
          r_next.own_bus = `CBA_ZERO1; // R05
          r_next.state = cba_pkg::CBA_GRANT;
        end else if (!is_arbiter && core_bus_need && !preempt) begin
          r_next.bus_request_line_out = `CBA_ONE1; // R09
          r_next.state = cba_pkg::CBA_REQ;
        end
      end
      cba_pkg::CBA_REQ: begin
        if (ext_grant && !preempt) begin
          r_next.own_bus = `CBA_ONE1; // R06
          r_next.state = cba_pkg::CBA_OWN;
        end
      end
      cba_pkg::CBA_OWN: begin
        if (!core_bus_need && !core_bus_active) begin
          r_next.own_bus = `CBA_ZERO1;
          r_next.bus_request_line_out = `CBA_ZERO1;
          r_next.state = cba_pkg::CBA_IDLE;
        end
      end
      cba_pkg::CBA_GRANT: begin
        // bus floated the cycle before grant rises
        r_next.grant_out = `CBA_ONE1; // R05
        if (!ext_req && !preempt && r_reg.grant_out) begin
          r_next.grant_out = `CBA_ZERO1; // R20
          r_next.state = cba_pkg::CBA_IDLE;
        end
      end
      cba_pkg::CBA_RST: begin
        if (r_reg.ack_cnt != `CBA_RST_ACK_HOLD) begin
          r_next.ack_cnt = r_reg.ack_cnt + 4'h1;
        end else begin
          r_next.reset_ack = `CBA_ZERO1;
          r_next.start_routine = `CBA_ONE1; // R17
          r_next.state = cba_pkg::CBA_IDLE;
        end
      end
      default: begin
        r_next.state = cba_pkg::CBA_IDLE;
      end
    endcase
    // reset request overrides any bus activity
    if (r_reg.state != cba_pkg::CBA_RST &&
        ((r_reg.rst_cnt == `CBA_RST_SAMPLES) || core_reset_exception)) begin
      r_next.reset_ack = `CBA_ONE1; // R16 R18
      r_next.ack_cnt = 4'h0;
      r_next.own_bus = `CBA_ZERO1;
      r_next.grant_out = `CBA_ZERO1;
      r_next.bus_request_line_out = `CBA_ZERO1;
      r_next.rst_cnt = 2'h0;
      r_next.state = cba_pkg::CBA_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus_owned = r_reg.own_bus;
  assign fault_seen = r_reg.fault;
  assign reset_routine_start = r_reg.start_routine;
  assign reset_ack_out = r_reg.reset_ack; // R16
  assign grant_acknowledge_o = r_reg.grant_out;
  assign grant_acknowledge_oe = is_arbiter; // R04
  assign bus_request_line_o = r_reg.bus_request_line_out;
  assign bus_request_line_oe = ~is_arbiter; // R07
  // abort marks the access for memory to ignore
  assign access_abort_out = core_cache_hit_discont | core_align_fault; // R10
  assign address_out = core_addr;
  assign address_strobe_out = core_as;
  assign data_strobe_out = core_ds;
  assign cycle_initiate_out = core_cycle_init;
  assign access_status_out = core_status;
  assign virtual_address_flag = core_vad;
  assign execution_level_out = core_xmd;
  assign addr_side_oe = r_reg.own_bus; // R03 R05
  assign data_out = core_wdata;
  assign data_ready_out = core_data_ready_out;
  assign transfer_size_out = core_size;
  assign read_write_out = core_read_write;
  assign data_side_oe = r_reg.own_bus & ~rel; // R12
  assign data_bus_oe = r_reg.own_bus & ~rel & core_data_we; // R12
endmodule

/* testbench/cba_chk.sv */
/* port checker for cba_core.
   assumes a bind from the bench top file. */
`timescale 1ns/1ns
module cba_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // watched inputs
  input wire logic arbiter_select_strap,
  input wire logic data_bus_release_in,
  input wire logic reset_request_in,
  input wire logic core_cache_hit_discont,
  input wire logic core_align_fault,
  input wire logic grant_acknowledge_i,
  // watched outputs
  input wire logic grant_acknowledge_o,
  input wire logic grant_acknowledge_oe,
  input wire logic bus_request_line_oe,
  input wire logic bus_owned,
  input wire logic addr_side_oe,
  input wire logic data_side_oe,
  input wire logic access_abort_out,
  input wire logic reset_ack_out,
  input wire logic reset_routine_start
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_GNT_DIR: assert property (grant_acknowledge_oe ==
    !arbiter_select_strap) else $error("grant pin direction");
  AST_REQ_DIR: assert property (bus_request_line_oe ==
    arbiter_select_strap) else $error("request pin direction");
  // a non-arbiter may drive only while the far arbiter grants
  AST_FLOAT: assert property (addr_side_oe |-> bus_owned &&
    (!arbiter_select_strap || grant_acknowledge_i))
    else $error("bus driven while not owned");
  AST_GNT_FLOAT: assert property (grant_acknowledge_o |->
    !addr_side_oe) else $error("grant while driving bus");
  AST_OWN: assert property (arbiter_select_strap && $rose(bus_owned)
    |-> $past(grant_acknowledge_i, 3)) else $error("owned without grant");
  AST_REL: assert property (data_bus_release_in[*3]
    |-> !data_side_oe) else $error("data side not released");
  AST_ABORT: assert property (core_cache_hit_discont ||
    core_align_fault |-> access_abort_out) else $error("no abort");
  AST_RST: assert property (reset_request_in[*2]
    |-> ##[0:4] reset_ack_out) else $error("reset not acknowledged");
  AST_ROUTINE: assert property (reset_routine_start
    |-> $fell(reset_ack_out)) else $error("routine before ack drop");
endmodule

/* testbench/cba_peer.sv */
/* far side: an arbiter granting lag+1 cycles after a request, held
   until the request drops; a master whose request follows want. */
`timescale 1ns/1ns
module cba_peer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bench commands and device request
  input wire logic want,
  input wire logic [1:0] lag,
  input wire logic req_o,
  // pin drives
  output logic bus_request_line_drv,
  output logic grant_drv
);
  logic [1:0] wait_reg;
  always_ff @(posedge ref_clk) begin
    bus_request_line_drv <= want;
    if (!rstn || !req_o) begin
      wait_reg <= 2'h0;
      grant_drv <= 1'h0;
    end else if (wait_reg == lag) begin
      grant_drv <= 1'h1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

/* testbench/cba_core_tb.sv */
/* bench for cba_core in both roles, with exceptions and reset.
   assumes cba_peer on the two-way pins; core values from a counter. */
`timescale 1ns/1ns
module cba_core_tb;
  logic ref_clk = 1'h0, rstn = 1'h0, arbiter_select_strap = 1'h0;
  logic data_bus_release_in = 1'h0, transfer_ack_in = 1'h0, want = 1'h0;
  logic reset_request_in = 1'h0, preemption_request_in = 1'h0;
  logic fault_in = 1'h0, core_bus_need = 1'h0, core_align_fault = 1'h0;
  logic core_cache_hit_discont = 1'h0, core_reset_exception = 1'h0;
  logic [1:0] lag = 2'h0;
  logic [31:0] cnt = 32'h0000_0000;
  logic [31:0] address_out;
  logic grant_acknowledge_o, grant_acknowledge_oe, bus_request_line_o;
  logic bus_request_line_oe, bus_request_line_drv, grant_drv, bus_owned, fault_seen;
  logic reset_routine_start, reset_ack_out, access_abort_out;
  logic addr_side_oe, data_side_oe, grant_acknowledge_i, bus_request_line_i;
  logic data_bus_oe;
  int num_errors = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cnt <= cnt + 32'h0000_0001;
  assign grant_acknowledge_i = grant_acknowledge_oe ? grant_acknowledge_o
    : grant_drv;
  assign bus_request_line_i = bus_request_line_oe ? bus_request_line_o
    : bus_request_line_drv;
  cba_peer cba_peer_inst (.ref_clk, .rstn, .want, .lag, .bus_request_line_drv,
    .req_o(bus_request_line_o & bus_request_line_oe), .grant_drv);
  cba_core cba_core_inst (.*, .core_bus_active(core_bus_need),
    .core_addr(cnt), .core_wdata(~cnt), .core_data_we(cnt[6]),
    .core_as(cnt[0]), .core_ds(cnt[1]), .core_cycle_init(cnt[2]),
    .core_data_ready_out(cnt[3]), .core_size(cnt[2:0]), .core_read_write(cnt[4]),
    .core_status(cnt[3:0]), .core_vad(cnt[5]), .core_xmd(cnt[1:0]),
    .address_strobe_out(), .data_strobe_out(), .cycle_initiate_out(),
    .access_status_out(), .virtual_address_flag(), .data_out(),
    .execution_level_out(), .data_ready_out(), .transfer_size_out(),
    .read_write_out(), .data_bus_oe(data_bus_oe));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic boot(input logic strap);
    rstn = 1'h0;
    arbiter_select_strap = strap;
    cyc(8);
    rstn = 1'h1;
    cyc(2);
  endtask
  task automatic t_arb;
    boot(1'h0);
    chk(bus_owned, 1'h1);
    core_align_fault = 1'h1;
    cyc(1);
    chk(access_abort_out, 1'h1);
    core_align_fault = 1'h0;
    core_cache_hit_discont = 1'h1;
    cyc(1);
    chk(access_abort_out, 1'h1);
    core_cache_hit_discont = 1'h0;
    want = 1'h1;
    repeat (10) if (grant_acknowledge_i !== 1'h1) cyc(1);
    chk({grant_acknowledge_i, addr_side_oe}, 2'h2);
    cyc(5);
    chk(grant_acknowledge_i, 1'h1);
    want = 1'h0;
    cyc(8);
    chk({grant_acknowledge_i, bus_owned}, 2'h1);
  endtask
  task automatic t_pre;
    boot(1'h0);
    preemption_request_in = 1'h1;
    want = 1'h1;
    cyc(8);
    chk(grant_acknowledge_i, 1'h0);
    preemption_request_in = 1'h0;
    repeat (10) if (grant_acknowledge_i !== 1'h1) cyc(1);
    chk(grant_acknowledge_i, 1'h1);
    want = 1'h0;
  endtask
  task automatic t_non;
    lag = 2'h3;
    boot(1'h1);
    chk({addr_side_oe, bus_request_line_o}, 2'h0);
    core_bus_need = 1'h1;
    cyc(1);
    chk(bus_request_line_o, 1'h1);
    repeat (12) if (bus_owned !== 1'h1) cyc(1);
    chk({grant_acknowledge_i, addr_side_oe}, 2'h3);
    chk(address_out, cnt);
    chk(data_bus_oe, cnt[6]);
    data_bus_release_in = 1'h1;
    cyc(3);
    chk({data_side_oe, data_bus_oe}, 2'h0);
    data_bus_release_in = 1'h0;
    core_bus_need = 1'h0;
    cyc(4);
    chk({bus_owned, bus_request_line_o}, 2'h0);
    lag = 2'h0;
  endtask
  task automatic t_flt;
    boot(1'h0);
    data_bus_release_in = 1'h1;
    cyc(3);
    fault_in = 1'h1;
    cyc(4);
    chk(fault_seen, 1'h0);
    fault_in = 1'h0;
    data_bus_release_in = 1'h0;
    cyc(4);
    fault_in = 1'h1;
    cyc(1);
    chk(fault_seen, 1'h0);
    cyc(3);
    chk(fault_seen, 1'h1);
    fault_in = 1'h0;
    transfer_ack_in = 1'h1;
    cyc(4);
    chk(fault_seen, 1'h0);
    fault_in = 1'h1;
    cyc(2);
    chk(fault_seen, 1'h1);
    fault_in = 1'h0;
    transfer_ack_in = 1'h0;
  endtask
  task automatic t_rst;
    boot(1'h0);
    reset_request_in = 1'h1;
    cyc(1);
    reset_request_in = 1'h0;
    cyc(5);
    chk(reset_ack_out, 1'h0);
    reset_request_in = 1'h1;
    cyc(2);
    reset_request_in = 1'h0;
    repeat (6) if (reset_ack_out !== 1'h1) cyc(1);
    chk(reset_ack_out, 1'h1);
    repeat (12) if (reset_routine_start !== 1'h1) cyc(1);
    chk({reset_routine_start, reset_ack_out}, 2'h2);
    core_reset_exception = 1'h1;
    cyc(1);
    core_reset_exception = 1'h0;
    repeat (4) if (reset_ack_out !== 1'h1) cyc(1);
    chk(reset_ack_out, 1'h1);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    t_arb();
    t_pre();
    t_non();
    t_flt();
    t_rst();
    close_out();
  end
  // the whole sequence takes about 140 cycles
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
endmodule
bind cba_core cba_chk cba_chk_inst (.*);
